// >>> src/rcsr_regs.sv
// AHB-Lite register slice of the packet radio: interrupt enables, receive status and configuration.
`timescale 1ns/10ps
module rcsr_regs (
  input  wire logic             hclk,        // Bus clock, 10 MHz.
  input  wire logic             hresetn,     // Asynchronous reset, active low.
  input  wire logic             hsel,        // Slave select.
  input  wire logic [31:0]      haddr,       // Byte address.
  input  wire logic [1:0]       htrans,      // Transfer type.
  input  wire logic             hwrite,      // Write when high.
  input  wire logic [2:0]       hsize,       // Transfer size, word only.
  input  wire logic [31:0]      hwdata,      // Write data.
  input  wire logic             hready,      // Bus ready.
  output logic      [31:0]      hrdata,      // Read data.
  output logic                  hreadyout,   // Slave ready.
  output logic                  hresp,       // Response, always OKAY.
  input  wire logic [31:0]      events,      // Event flags from the radio core.
  input  wire logic             start_task,  // Start task pulse.
  input  wire rcsr_pkg::rcsr_rx_s rx,        // Receive results.
  output rcsr_pkg::rcsr_cfg_s   cfg,         // Settings to the radio core.
  output logic                  irq          // Peripheral interrupt.
);

  typedef struct packed {
    logic                ready;
    logic                dp_write;
    logic [11:0]         dp_addr;
    logic [31:0]         rdata;
    logic [31:0]         irq_mask;
    logic                crc_ok;
    logic [2:0]          logic_addr;
    logic [23:0]         check_field;
    logic [2:0]          dev_index;
    logic                len_over;
    logic [7:0]          stored_len;
    logic [31:0]         pkt_ptr;
    logic [6:0]          freq;
    logic                map_low;
    logic [7:0]          power;
    rcsr_pkg::rcsr_rate_e rate;
    logic [31:0]         fmt_a;
    logic [31:0]         fmt_b;
    logic                preamble_16;
    logic [11:0]         carrier;
    logic                hdr2_in_ram;
    logic                irq;
  } rcsr_state_s;

  rcsr_state_s st_reg;
  rcsr_state_s st_next;
  logic        addr_phase;
  logic [11:0] addr_lo;
  logic [7:0]  max_len;

  function automatic logic rcsr_rate_legal(input logic [31:0] v);
    logic [3:0] c;
    c = v[rcsr_pkg::RATE_W-1:0];
    rcsr_rate_legal = (v[31:rcsr_pkg::RATE_W] == 28'h0000000) &&
                      (c == rcsr_pkg::RCSR_RATE_PROP_1M || c == rcsr_pkg::RCSR_RATE_PROP_2M ||
                       c == rcsr_pkg::RCSR_RATE_STD_1M  || c == rcsr_pkg::RCSR_RATE_STD_2M);
  endfunction

  function automatic logic [11:0] rcsr_carrier(input logic map_low, input logic [6:0] freq);
    rcsr_carrier = (map_low ? rcsr_pkg::BASE_LOW_MHZ : rcsr_pkg::BASE_DEFAULT_MHZ) + {5'h00, freq};
  endfunction

  function automatic logic [31:0] rcsr_read(input rcsr_state_s s, input logic [11:0] a);
    rcsr_read = 32'h00000000;
    unique case (a)
      rcsr_pkg::OFS_IRQ_ENABLE,
      rcsr_pkg::OFS_IRQ_DISABLE: rcsr_read = s.irq_mask;
      rcsr_pkg::OFS_CRC_RESULT:  rcsr_read = {31'h00000000, s.crc_ok};
      rcsr_pkg::OFS_LOGIC_ADDR:  rcsr_read = {29'h00000000, s.logic_addr};
      rcsr_pkg::OFS_CHECK_FIELD: rcsr_read = {8'h00, s.check_field};
      rcsr_pkg::OFS_DEV_INDEX:   rcsr_read = {29'h00000000, s.dev_index};
      rcsr_pkg::OFS_LEN_STATUS:  rcsr_read = {31'h00000000, s.len_over};
      rcsr_pkg::OFS_PKT_PTR:     rcsr_read = s.pkt_ptr;
      rcsr_pkg::OFS_FREQUENCY:   rcsr_read = {23'h000000, s.map_low, 1'b0, s.freq};
      rcsr_pkg::OFS_POWER:       rcsr_read = {24'h000000, s.power};
      rcsr_pkg::OFS_MODE:        rcsr_read = {28'h0000000, s.rate};
      rcsr_pkg::OFS_FORMAT_A:    rcsr_read = s.fmt_a;
      rcsr_pkg::OFS_FORMAT_B:    rcsr_read = s.fmt_b;
      default:                   rcsr_read = 32'h00000000;
    endcase
  endfunction

  assign addr_phase = hsel && htrans[1] && hready;
  assign addr_lo    = haddr[11:0];
  assign max_len    = st_reg.fmt_b[rcsr_pkg::MAX_LEN_LSB +: rcsr_pkg::MAX_LEN_W];

  always_comb begin
    st_next          = st_reg;
    st_next.ready    = 1'b1;
    st_next.dp_write = addr_phase && hwrite;
    st_next.dp_addr  = addr_lo;

    // Write data arrives one cycle after the address phase.
    if (st_reg.dp_write) begin
      unique case (st_reg.dp_addr)
        rcsr_pkg::OFS_IRQ_ENABLE: begin
          st_next.irq_mask = st_reg.irq_mask | (hwdata & rcsr_pkg::IRQ_VALID_MASK);
        end
        rcsr_pkg::OFS_IRQ_DISABLE: begin
          st_next.irq_mask = st_reg.irq_mask & ~(hwdata & rcsr_pkg::IRQ_VALID_MASK);
        end
        rcsr_pkg::OFS_PKT_PTR: begin
          st_next.pkt_ptr = hwdata;
        end
        rcsr_pkg::OFS_FREQUENCY: begin
          st_next.map_low = hwdata[rcsr_pkg::MAP_BIT];
          // Channels above the band edge are refused and the old channel kept.
          if (hwdata[rcsr_pkg::FREQ_W-1:0] <= rcsr_pkg::FREQ_MAX) begin
            st_next.freq = hwdata[rcsr_pkg::FREQ_W-1:0];
          end
        end
        rcsr_pkg::OFS_POWER: begin
          st_next.power = hwdata[rcsr_pkg::POWER_W-1:0];
        end
        rcsr_pkg::OFS_MODE: begin
          if (rcsr_rate_legal(hwdata)) begin
            st_next.rate = rcsr_pkg::rcsr_rate_e'(hwdata[rcsr_pkg::RATE_W-1:0]);
          end
        end
        rcsr_pkg::OFS_FORMAT_A: begin
          st_next.fmt_a = hwdata & rcsr_pkg::FMT_A_WMASK;
        end
        rcsr_pkg::OFS_FORMAT_B: begin
          st_next.fmt_b = hwdata & rcsr_pkg::FMT_B_WMASK;
        end
        default: begin
          st_next.dp_write = addr_phase && hwrite;
        end
      endcase
    end

    // Receive results are caught when the radio core finishes a packet.
    if (rx.capture) begin
      st_next.crc_ok      = rx.crc_ok;
      st_next.logic_addr  = rx.logic_addr;
      st_next.check_field = rx.check_field;
      st_next.dev_index   = rx.dev_index;
      st_next.len_over    = rx.payload_len > max_len;
      st_next.stored_len  = (rx.payload_len > max_len) ? max_len : rx.payload_len;
    end

    if (start_task) begin
      st_next.preamble_16 = st_reg.fmt_a[rcsr_pkg::PREAMBLE_BIT];
    end

    st_next.carrier     = rcsr_carrier(st_next.map_low, st_next.freq);
    st_next.hdr2_in_ram = st_next.fmt_a[rcsr_pkg::HDR2_STORE_BIT] ||
                          (st_next.fmt_a[rcsr_pkg::HDR2_BITS_LSB +: rcsr_pkg::HDR2_BITS_W] != 4'h0);
    st_next.irq         = |(events & st_reg.irq_mask);

    // Read data is taken from the next state so a write just before is seen.
    st_next.rdata = (addr_phase && !hwrite) ? rcsr_read(st_next, addr_lo) : 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg         <= '0;
      st_reg.ready   <= 1'b1;
      st_reg.freq    <= rcsr_pkg::FREQ_RESET;
      st_reg.carrier <= rcsr_pkg::BASE_DEFAULT_MHZ + {5'h00, rcsr_pkg::FREQ_RESET};
      st_reg.rate    <= rcsr_pkg::RCSR_RATE_PROP_1M;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata    = st_reg.rdata;
  assign hreadyout = st_reg.ready;
  assign hresp     = 1'b0 & st_reg.ready;
  assign irq       = st_reg.irq;

  assign cfg.packet_ram_pointer  = st_reg.pkt_ptr;
  assign cfg.carrier_mhz         = st_reg.carrier;
  assign cfg.map_low             = st_reg.map_low;
  assign cfg.output_power_level  = st_reg.power;
  assign cfg.rate                = st_reg.rate;
  assign cfg.length_field_bits   = st_reg.fmt_a[rcsr_pkg::LEN_BITS_LSB +: rcsr_pkg::LEN_BITS_W];
  assign cfg.first_header_bytes  = st_reg.fmt_a[rcsr_pkg::HDR1_BYTES_BIT];
  assign cfg.second_header_bits  = st_reg.fmt_a[rcsr_pkg::HDR2_BITS_LSB +: rcsr_pkg::HDR2_BITS_W];
  assign cfg.second_header_store = st_reg.hdr2_in_ram;
  assign cfg.preamble_size       = st_reg.preamble_16;
  assign cfg.length_counts_check = st_reg.fmt_a[rcsr_pkg::LEN_CHECK_BIT];
  assign cfg.max_payload_bytes   = max_len;
  assign cfg.stored_payload_len  = st_reg.stored_len;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_set_enables;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_IRQ_ENABLE
      |=> ((st_reg.irq_mask & $past(hwdata) & rcsr_pkg::IRQ_VALID_MASK) ==
           ($past(hwdata) & rcsr_pkg::IRQ_VALID_MASK));
  endproperty
  a_set_enables: assert property (p_set_enables) else $error("enable write did not set mask bits");

  property p_clear_disables;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_IRQ_DISABLE
      |=> ((st_reg.irq_mask & $past(hwdata) & rcsr_pkg::IRQ_VALID_MASK) == 32'h00000000);
  endproperty
  a_clear_disables: assert property (p_clear_disables) else $error("disable write left mask bits set");

  property p_mask_bits_valid;
    (st_reg.irq_mask & ~rcsr_pkg::IRQ_VALID_MASK) == 32'h00000000;
  endproperty
  a_mask_bits_valid: assert property (p_mask_bits_valid) else $error("mask holds an unassigned bit");

  property p_zero_keeps_mask;
    !st_reg.dp_write |=> $stable(st_reg.irq_mask);
  endproperty
  a_zero_keeps_mask: assert property (p_zero_keeps_mask) else $error("mask changed without a write");

  property p_rx_capture;
    rx.capture |=> st_reg.crc_ok == $past(rx.crc_ok) && st_reg.logic_addr == $past(rx.logic_addr) &&
                   st_reg.check_field == $past(rx.check_field) && st_reg.dev_index == $past(rx.dev_index);
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("receive status not captured");

  property p_len_truncate;
    rx.capture |=> st_reg.len_over == ($past(rx.payload_len) > $past(max_len)) &&
                   st_reg.stored_len <= $past(max_len);
  endproperty
  a_len_truncate: assert property (p_len_truncate) else $error("payload length status wrong");

  property p_freq_range;
    st_reg.freq <= rcsr_pkg::FREQ_MAX;
  endproperty
  a_freq_range: assert property (p_freq_range) else $error("channel beyond band edge");

  property p_carrier;
    st_reg.carrier == rcsr_carrier(st_reg.map_low, st_reg.freq);
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier does not follow channel and map");

  property p_rate_legal;
    rcsr_rate_legal({28'h0000000, st_reg.rate});
  endproperty
  a_rate_legal: assert property (p_rate_legal) else $error("illegal rate code stored");

  property p_irq_follows;
    ##1 st_reg.irq == (|($past(events) & $past(st_reg.irq_mask)));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt does not follow enabled events");

  property p_preamble_hold;
    !start_task |=> $stable(st_reg.preamble_16);
  endproperty
  a_preamble_hold: assert property (p_preamble_hold) else $error("preamble changed outside start");

  property p_hdr2_store;
    st_reg.hdr2_in_ram == (st_reg.fmt_a[rcsr_pkg::HDR2_STORE_BIT] ||
                           (st_reg.fmt_a[rcsr_pkg::HDR2_BITS_LSB +: rcsr_pkg::HDR2_BITS_W] != 4'h0));
  endproperty
  a_hdr2_store: assert property (p_hdr2_store) else $error("second header storage wrong");

  property p_read_mask;
    addr_phase && !hwrite && addr_lo == rcsr_pkg::OFS_IRQ_DISABLE && !st_reg.dp_write
      |=> hrdata == $past(st_reg.irq_mask);
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("disable register read wrong");

  property p_set_keeps;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_IRQ_ENABLE
      |=> ((st_reg.irq_mask & $past(st_reg.irq_mask)) == $past(st_reg.irq_mask));
  endproperty
  a_set_keeps: assert property (p_set_keeps) else $error("enable write cleared a mask bit");

  property p_clear_keeps;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_IRQ_DISABLE
      |=> ((st_reg.irq_mask & ~$past(st_reg.irq_mask)) == 32'h00000000);
  endproperty
  a_clear_keeps: assert property (p_clear_keeps) else $error("disable write set a mask bit");

  property p_read_crc;
    addr_phase && !hwrite && addr_lo == rcsr_pkg::OFS_CRC_RESULT && !rx.capture
      |=> hrdata == {31'h00000000, $past(st_reg.crc_ok)};
  endproperty
  a_read_crc: assert property (p_read_crc) else $error("check result read wrong");

  property p_read_logic;
    addr_phase && !hwrite && addr_lo == rcsr_pkg::OFS_LOGIC_ADDR && !rx.capture
      |=> hrdata == {29'h00000000, $past(st_reg.logic_addr)};
  endproperty
  a_read_logic: assert property (p_read_logic) else $error("logical address read wrong");

  property p_read_check;
    addr_phase && !hwrite && addr_lo == rcsr_pkg::OFS_CHECK_FIELD && !rx.capture
      |=> hrdata == {8'h00, $past(st_reg.check_field)};
  endproperty
  a_read_check: assert property (p_read_check) else $error("check field read wrong");

  property p_read_dev;
    addr_phase && !hwrite && addr_lo == rcsr_pkg::OFS_DEV_INDEX && !rx.capture
      |=> hrdata == {29'h00000000, $past(st_reg.dev_index)};
  endproperty
  a_read_dev: assert property (p_read_dev) else $error("device index read wrong");

  property p_read_len;
    addr_phase && !hwrite && addr_lo == rcsr_pkg::OFS_LEN_STATUS && !rx.capture
      |=> hrdata == {31'h00000000, $past(st_reg.len_over)};
  endproperty
  a_read_len: assert property (p_read_len) else $error("length status read wrong");

  property p_ptr_write;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_PKT_PTR |=> st_reg.pkt_ptr == $past(hwdata);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer write not stored");

  property p_ptr_hold;
    !(st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_PKT_PTR) |=> $stable(st_reg.pkt_ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed without a write");

  property p_freq_refuse;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_FREQUENCY &&
      hwdata[rcsr_pkg::FREQ_W-1:0] > rcsr_pkg::FREQ_MAX |=> $stable(st_reg.freq);
  endproperty
  a_freq_refuse: assert property (p_freq_refuse) else $error("channel beyond band edge taken");

  property p_map_write;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_FREQUENCY
      |=> cfg.map_low == $past(hwdata[rcsr_pkg::MAP_BIT]);
  endproperty
  a_map_write: assert property (p_map_write) else $error("map select not stored");

  property p_power_write;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_POWER
      |=> cfg.output_power_level == $past(hwdata[rcsr_pkg::POWER_W-1:0]);
  endproperty
  a_power_write: assert property (p_power_write) else $error("power byte not stored");

  property p_rate_refuse;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_MODE && !rcsr_rate_legal(hwdata)
      |=> $stable(st_reg.rate);
  endproperty
  a_rate_refuse: assert property (p_rate_refuse) else $error("illegal rate write taken");

  property p_len_bits;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_FORMAT_A
      |=> cfg.length_field_bits == $past(hwdata[rcsr_pkg::LEN_BITS_LSB +: rcsr_pkg::LEN_BITS_W]);
  endproperty
  a_len_bits: assert property (p_len_bits) else $error("length field size wrong");

  property p_hdr_sizes;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_FORMAT_A
      |=> cfg.second_header_bits == $past(hwdata[rcsr_pkg::HDR2_BITS_LSB +: rcsr_pkg::HDR2_BITS_W]);
  endproperty
  a_hdr_sizes: assert property (p_hdr_sizes) else $error("header field size wrong");

  property p_len_check;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_FORMAT_A
      |=> cfg.length_counts_check == $past(hwdata[rcsr_pkg::LEN_CHECK_BIT]);
  endproperty
  a_len_check: assert property (p_len_check) else $error("length-counts-check bit wrong");

  property p_max_len;
    st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_FORMAT_B
      |=> cfg.max_payload_bytes == $past(hwdata[rcsr_pkg::MAX_LEN_LSB +: rcsr_pkg::MAX_LEN_W]);
  endproperty
  a_max_len: assert property (p_max_len) else $error("maximum payload length wrong");

  c_enable_write: cover property (st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_IRQ_ENABLE);
  c_rx_over:      cover property (rx.capture && rx.payload_len > max_len);
  c_irq_rise:     cover property (!st_reg.irq ##1 st_reg.irq);
  c_start_pre16:  cover property (start_task && st_reg.fmt_a[rcsr_pkg::PREAMBLE_BIT]);
  c_freq_refuse:  cover property (st_reg.dp_write && st_reg.dp_addr == rcsr_pkg::OFS_FREQUENCY &&
                                  hwdata[rcsr_pkg::FREQ_W-1:0] > rcsr_pkg::FREQ_MAX);

endmodule

// >>> src/rcsr_pkg.sv
// Register map, field layouts and carrier types of the radio register slice.
package rcsr_pkg;
  // Byte offsets within the radio register window.
  localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h304;
  localparam logic [11:0] OFS_IRQ_DISABLE = 12'h308;
  localparam logic [11:0] OFS_CRC_RESULT  = 12'h400;
  localparam logic [11:0] OFS_LOGIC_ADDR  = 12'h408;
  localparam logic [11:0] OFS_CHECK_FIELD = 12'h40C;
  localparam logic [11:0] OFS_DEV_INDEX   = 12'h410;
  localparam logic [11:0] OFS_LEN_STATUS  = 12'h414;
  localparam logic [11:0] OFS_PKT_PTR     = 12'h504;
  localparam logic [11:0] OFS_FREQUENCY   = 12'h508;
  localparam logic [11:0] OFS_POWER       = 12'h50C;
  localparam logic [11:0] OFS_MODE        = 12'h510;
  localparam logic [11:0] OFS_FORMAT_A    = 12'h514;
  localparam logic [11:0] OFS_FORMAT_B    = 12'h518;

  // Event bits that own an enable: ready..bit count, check good/bad, tx/rx ready, header, last bit.
  localparam logic [31:0] IRQ_VALID_MASK  = 32'h80E00DFF;

  // Frequency register layout and carrier arithmetic.
  localparam int          FREQ_W          = 7;
  localparam int          MAP_BIT         = 8;
  localparam logic [6:0]  FREQ_MAX        = 7'h64;
  localparam logic [6:0]  FREQ_RESET      = 7'h02;
  localparam logic [11:0] BASE_DEFAULT_MHZ = 12'h960;
  localparam logic [11:0] BASE_LOW_MHZ    = 12'h938;

  // Output power byte and rate field widths.
  localparam int          POWER_W         = 8;
  localparam int          RATE_W          = 4;

  // First packet format register layout.
  localparam int          LEN_BITS_LSB    = 0;
  localparam int          LEN_BITS_W      = 4;
  localparam int          HDR1_BYTES_BIT  = 8;
  localparam int          HDR2_BITS_LSB   = 16;
  localparam int          HDR2_BITS_W     = 4;
  localparam int          HDR2_STORE_BIT  = 20;
  localparam int          PREAMBLE_BIT    = 24;
  localparam int          LEN_CHECK_BIT   = 26;
  localparam logic [31:0] FMT_A_WMASK     = 32'h051F010F;

  // Second packet format register: max length, static length, base length, endian, whitening.
  localparam int          MAX_LEN_LSB     = 0;
  localparam int          MAX_LEN_W       = 8;
  localparam logic [31:0] FMT_B_WMASK     = 32'h0307FFFF;

  typedef enum logic [3:0] {
    RCSR_RATE_PROP_1M = 4'h0,
    RCSR_RATE_PROP_2M = 4'h1,
    RCSR_RATE_STD_1M  = 4'h3,
    RCSR_RATE_STD_2M  = 4'h4
  } rcsr_rate_e;

  // Results that the receive path hands over when a packet completes.
  typedef struct packed {
    logic        capture;
    logic        crc_ok;
    logic [2:0]  logic_addr;
    logic [23:0] check_field;
    logic [2:0]  dev_index;
    logic [7:0]  payload_len;
  } rcsr_rx_s;

  // Settings that steer the radio core.
  typedef struct packed {
    logic [31:0] packet_ram_pointer;
    logic [11:0] carrier_mhz;
    logic        map_low;
    logic [7:0]  output_power_level;
    rcsr_rate_e  rate;
    logic [3:0]  length_field_bits;
    logic        first_header_bytes;
    logic [3:0]  second_header_bits;
    logic        second_header_store;
    logic        preamble_size;
    logic        length_counts_check;
    logic [7:0]  max_payload_bytes;
    logic [7:0]  stored_payload_len;
  } rcsr_cfg_s;
endpackage

// >>> tb/rcsr_regs_tb.sv
// Self-checking testbench for the radio register slice over its AHB-Lite port.
`timescale 1ns/10ps
module rcsr_regs_tb;
  logic                hclk;
  logic                hresetn;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic                hready;
  logic [31:0]         hrdata;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         events;
  logic                start_task;
  rcsr_pkg::rcsr_rx_s  rx;
  rcsr_pkg::rcsr_cfg_s cfg;
  logic                irq;
  int                  errors;
  int                  tests_run;
  int                  cycles;
  logic [11:0]         ofs [13];
  logic [3:0]          codes [4];

  assign hready = hreadyout;

  rcsr_regs dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .events(events), .start_task(start_task), .rx(rx), .cfg(cfg), .irq(irq)
  );

  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One single transfer: address phase held until hready, then data phase held until hready.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h00000000;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, q);
    check(q, exp);
  endtask

  task automatic capture(input logic ok, input logic [2:0] la, input logic [23:0] cf,
                         input logic [2:0] di, input logic [7:0] len);
    rx <= '{capture: 1'b1, crc_ok: ok, logic_addr: la, check_field: cf, dev_index: di, payload_len: len};
    @(posedge hclk);
    rx.capture <= 1'b0;
    @(posedge hclk);
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    events = 32'h00000000;
    start_task = 1'b0;
    rx = '0;
    errors = 0;
    tests_run = 0;
    cycles = 0;
    ofs = '{rcsr_pkg::OFS_IRQ_ENABLE, rcsr_pkg::OFS_IRQ_DISABLE, rcsr_pkg::OFS_CRC_RESULT,
            rcsr_pkg::OFS_LOGIC_ADDR, rcsr_pkg::OFS_CHECK_FIELD, rcsr_pkg::OFS_DEV_INDEX,
            rcsr_pkg::OFS_LEN_STATUS, rcsr_pkg::OFS_PKT_PTR, rcsr_pkg::OFS_FREQUENCY,
            rcsr_pkg::OFS_POWER, rcsr_pkg::OFS_MODE, rcsr_pkg::OFS_FORMAT_A, rcsr_pkg::OFS_FORMAT_B};
    codes = '{4'h0, 4'h1, 4'h3, 4'h4};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ofs[i])
      rd_chk(ofs[i], (ofs[i] == rcsr_pkg::OFS_FREQUENCY) ? 32'h00000002 : 32'h00000000);
    check(32'(cfg.carrier_mhz), 32'h00000962);
    check(32'(irq), 32'h00000000);
    $display("Test reset values done");

    wr(rcsr_pkg::OFS_IRQ_ENABLE, 32'hFFFFFFFF);
    rd_chk(rcsr_pkg::OFS_IRQ_ENABLE, 32'h80E00DFF);
    wr(rcsr_pkg::OFS_IRQ_ENABLE, 32'h00000000);
    wr(rcsr_pkg::OFS_IRQ_DISABLE, 32'h00000000);
    rd_chk(rcsr_pkg::OFS_IRQ_DISABLE, 32'h80E00DFF);
    wr(rcsr_pkg::OFS_IRQ_DISABLE, 32'h00000401);
    rd_chk(rcsr_pkg::OFS_IRQ_ENABLE, 32'h80E009FE);
    events <= 32'h00000401;
    repeat (3) @(posedge hclk);
    check(32'(irq), 32'h00000000);
    events <= 32'h00000002;
    repeat (3) @(posedge hclk);
    check(32'(irq), 32'h00000001);
    wr(rcsr_pkg::OFS_IRQ_DISABLE, 32'h00000002);
    repeat (2) @(posedge hclk);
    check(32'(irq), 32'h00000000);
    events <= 32'h00000000;
    $display("Test interrupt mask done");

    wr(rcsr_pkg::OFS_FORMAT_B, 32'h0000000A);
    rd_chk(rcsr_pkg::OFS_FORMAT_B, 32'h0000000A);
    check(32'(cfg.max_payload_bytes), 32'h0000000A);
    capture(1'b1, 3'h5, 24'hA5C3F1, 3'h6, 8'h14);
    rd_chk(rcsr_pkg::OFS_CRC_RESULT, 32'h00000001);
    rd_chk(rcsr_pkg::OFS_LOGIC_ADDR, 32'h00000005);
    rd_chk(rcsr_pkg::OFS_CHECK_FIELD, 32'h00A5C3F1);
    rd_chk(rcsr_pkg::OFS_DEV_INDEX, 32'h00000006);
    rd_chk(rcsr_pkg::OFS_LEN_STATUS, 32'h00000001);
    check(32'(cfg.stored_payload_len), 32'h0000000A);
    capture(1'b0, 3'h2, 24'h123456, 3'h1, 8'h07);
    rd_chk(rcsr_pkg::OFS_CRC_RESULT, 32'h00000000);
    rd_chk(rcsr_pkg::OFS_LOGIC_ADDR, 32'h00000002);
    rd_chk(rcsr_pkg::OFS_CHECK_FIELD, 32'h00123456);
    rd_chk(rcsr_pkg::OFS_DEV_INDEX, 32'h00000001);
    rd_chk(rcsr_pkg::OFS_LEN_STATUS, 32'h00000000);
    check(32'(cfg.stored_payload_len), 32'h00000007);
    $display("Test receive status done");

    wr(rcsr_pkg::OFS_PKT_PTR, 32'h20001233);
    rd_chk(rcsr_pkg::OFS_PKT_PTR, 32'h20001233);
    check(cfg.packet_ram_pointer, 32'h20001233);
    wr(rcsr_pkg::OFS_FREQUENCY, 32'h00000064);
    rd_chk(rcsr_pkg::OFS_FREQUENCY, 32'h00000064);
    check(32'(cfg.carrier_mhz), 32'h000009C4);
    wr(rcsr_pkg::OFS_FREQUENCY, 32'h00000165);
    rd_chk(rcsr_pkg::OFS_FREQUENCY, 32'h00000164);
    check(32'(cfg.carrier_mhz), 32'h0000099C);
    check(32'(cfg.map_low), 32'h00000001);
    wr(rcsr_pkg::OFS_POWER, 32'h000000FC);
    rd_chk(rcsr_pkg::OFS_POWER, 32'h000000FC);
    check(32'(cfg.output_power_level), 32'h000000FC);
    foreach (codes[i]) begin
      wr(rcsr_pkg::OFS_MODE, 32'(codes[i]));
      rd_chk(rcsr_pkg::OFS_MODE, 32'(codes[i]));
      check(32'(cfg.rate), 32'(codes[i]));
    end
    wr(rcsr_pkg::OFS_MODE, 32'h00000002);
    rd_chk(rcsr_pkg::OFS_MODE, 32'h00000004);
    $display("Test configuration done");

    wr(rcsr_pkg::OFS_FORMAT_A, 32'hFFFFFFFF);
    rd_chk(rcsr_pkg::OFS_FORMAT_A, 32'h051F010F);
    check(32'(cfg.length_field_bits), 32'h0000000F);
    check(32'(cfg.first_header_bytes), 32'h00000001);
    check(32'(cfg.second_header_bits), 32'h0000000F);
    check(32'(cfg.second_header_store), 32'h00000001);
    check(32'(cfg.length_counts_check), 32'h00000001);
    check(32'(cfg.preamble_size), 32'h00000000);
    start_task <= 1'b1;
    @(posedge hclk);
    start_task <= 1'b0;
    @(posedge hclk);
    check(32'(cfg.preamble_size), 32'h00000001);
    wr(rcsr_pkg::OFS_FORMAT_A, 32'h00000000);
    rd_chk(rcsr_pkg::OFS_FORMAT_A, 32'h00000000);
    check(32'(cfg.second_header_store), 32'h00000000);
    check(32'(cfg.preamble_size), 32'h00000001);
    wr(rcsr_pkg::OFS_FORMAT_A, 32'h00010000);
    rd_chk(rcsr_pkg::OFS_FORMAT_A, 32'h00010000);
    check(32'(cfg.second_header_store), 32'h00000001);
    $display("Test packet format done");

    wr(12'h600, 32'hFFFFFFFF);
    rd_chk(12'h600, 32'h00000000);
    rd_chk(rcsr_pkg::OFS_IRQ_ENABLE, 32'h80E009FC);
    wr(rcsr_pkg::OFS_CRC_RESULT, 32'hFFFFFFFF);
    rd_chk(rcsr_pkg::OFS_CRC_RESULT, 32'h00000000);
    check(32'(hresp), 32'h00000000);
    $display("Test unmapped and read-only done");
    wrap_up();
  end
endmodule
